// File: design/eil_pkg.sv
package eil_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] EIL_OFS_STATUS_CONTROL = 8'h1d;
	localparam logic [7:0] EIL_OFS_CONFIG_TWO     = 8'h1e;
	localparam logic [7:0] EIL_OFS_BREAK_CTRL     = 8'h1f;
	localparam logic [7:0] EIL_OFS_EVT_STATUS     = 8'h20;
	localparam logic [7:0] EIL_OFS_EVT_CLEAR      = 8'h21;
	localparam logic [7:0] EIL_OFS_EVT_ENABLE     = 8'h22;

	// Status and control field positions
	localparam int EIL_BIT_MODE    = 0;
	localparam int EIL_BIT_MASK    = 1;
	localparam int EIL_BIT_ACK     = 2;
	localparam int EIL_BIT_PENDING = 3;
	// Configuration two and break control field positions
	localparam int EIL_BIT_PUD     = 0;
	localparam int EIL_BIT_BREAK_CLEAR_ENABLE    = 0;
	// Event bits: request latched, request cleared
	localparam int EIL_EVT_SET     = 0;
	localparam int EIL_EVT_CLR     = 1;
	localparam int EIL_EVT_W       = 2;

	// Vector locations fetched when the request is taken
	localparam logic [15:0] EIL_VEC_HIGH = 16'hfffa;
	localparam logic [15:0] EIL_VEC_LOW  = 16'hfffb;

	// Reset values
	localparam logic        EIL_RST_MODE = 1'h0;
	localparam logic        EIL_RST_MASK = 1'h0;
	localparam logic        EIL_RST_PUD  = 1'h0;
	localparam logic        EIL_RST_BREAK_CLEAR_ENABLE = 1'h0;

endpackage

// File: design/eil_sync_if.sv
`timescale 1ns/1ps
interface eil_sync_if;
	logic pin_level;
	logic fall_pulse;
	modport producer (output pin_level, output fall_pulse);
	modport consumer (input pin_level, input fall_pulse);
endinterface

// File: design/eil_pin_sync.sv
`timescale 1ns/1ps
module eil_pin_sync
	import eil_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    sys_rst,
	input  wire logic    irq_pin_n,
	eil_sync_if.producer sy
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} eil_sync_s;

	eil_sync_s st_reg;
	eil_sync_s st_next;

	////////////////////////////////////////////////////////////////////////
	// Two stages before use; third holds the previous settled sample
	always_comb begin
		st_next    = st_reg;
		st_next.s1 = irq_pin_n;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
	end

	// Pin idles high through its pull-up, so reset to one
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '{s1: 1'h1, s2: 1'h1, s3: 1'h1};
		end else begin
			st_reg <= st_next;
		end
	end

	// Falling edge from consecutive settled samples
	assign sy.pin_level  = st_reg.s2;
	assign sy.fall_pulse = st_reg.s3 & ~st_reg.s2;

	fall_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sy.fall_pulse |-> $past(st_reg.s2) && !st_reg.s2)
		else $error("edge pulse without a high to low step");
endmodule

// File: design/eil_ext_irq.sv
`timescale 1ns/1ps
// Behaviour
// - A qualifying low on the pin sets the request latch.
// - Vector fetch, acknowledge write or reset clears the latch, per mode.
// - Level mode: request drops only after acknowledge or fetch and pin high, any order.
// - Level mode: request stays pending while the pin is low.
// - Edge mode: falling edges only; acknowledge or fetch clears at once.
// - Acknowledge bit is write-only, reads zero, writing one clears latch.
// - A falling edge after an acknowledge latches a new request.
// - Unmasked latched request goes to the processor, vector at FFFA/FFFB.
// - Reset clears latch and mode bit even with the pin low.
// - Pending flag reads the latch regardless of the module mask.
// - Module mask one blocks requests; zero enables; reset clears it.
// - Mode bit one selects edge and level, zero edge only; reset clears.
// - Pull-up disable bit at 1E disconnects the pin pull-up when one.
// - In break with clear-enable set, acknowledge clears and stays cleared.
// - In break with clear-enable clear, acknowledge leaves the latch alone.
// - Current pin level is offered to the pin-level branch instructions.
// - The processor global interrupt mask also blocks the request.
module eil_ext_irq
	import eil_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        irq_pin_n,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        vector_fetch,
	input  wire logic        break_state,
	input  wire logic        cpu_global_mask,
	output logic             cpu_irq_req,
	output logic      [15:0] cpu_vector_addr,
	output logic             pin_level_high,
	output logic             pin_pullup_en,
	output logic             evt_irq
);
	typedef struct packed {
		logic                 latch;
		logic                 ack_seen;
		logic                 mode;
		logic                 mask;
		logic                 pud;
		logic                 break_clear_enable;
		logic [EIL_EVT_W-1:0] evt_sts;
		logic [EIL_EVT_W-1:0] evt_en;
		logic [7:0]           rdata;
	} eil_state_s;

	eil_state_s st_reg;
	eil_state_s st_next;

	eil_sync_if sy ();

	eil_pin_sync u_sync (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.irq_pin_n (irq_pin_n),
		.sy        (sy)
	);

	logic                 ack_wr;
	logic                 ack_ok;
	logic                 clr_req;
	logic                 set_req;
	logic [EIL_EVT_W-1:0] evt_hit;
	logic [EIL_EVT_W-1:0] evt_clr;

	////////////////////////////////////////////////////////////////////////
	// Acknowledge qualification; in break it needs the clear-enable
	always_comb begin
		ack_wr  = reg_wr && reg_addr == EIL_OFS_STATUS_CONTROL && reg_wdata[EIL_BIT_ACK];
		ack_ok  = ack_wr && (!break_state || st_reg.break_clear_enable);
		clr_req = ack_ok || vector_fetch;
		// Edges always qualify; low level only in level mode
		set_req = sy.fall_pulse || (st_reg.mode && !sy.pin_level);
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for latch, control bits and read data
	always_comb begin
		st_next       = st_reg;
		st_next.rdata = 8'h00;
		// A fresh edge always wins and forgets any earlier acknowledge
		if (sy.fall_pulse) begin
			st_next.latch    = 1'h1;
			st_next.ack_seen = 1'h0;
		end else if (!st_reg.mode) begin
			// Edge mode: acknowledge or fetch clears at once, pin level ignored
			st_next.ack_seen = 1'h0;
			if (clr_req) begin
				st_next.latch = 1'h0;
			end
		end else begin
			// Level mode: the acknowledge is remembered until the pin is high,
			// otherwise an early ack would be lost while the pin stays low
			st_next.latch    = st_reg.latch || !sy.pin_level;
			st_next.ack_seen = st_next.latch && (st_reg.ack_seen || clr_req);
			if (sy.pin_level && st_next.ack_seen) begin
				st_next.latch    = 1'h0;
				st_next.ack_seen = 1'h0;
			end
		end
		// Writes to the control registers
		if (reg_wr) begin
			case (reg_addr)
				EIL_OFS_STATUS_CONTROL: begin
					st_next.mode = reg_wdata[EIL_BIT_MODE];
					st_next.mask = reg_wdata[EIL_BIT_MASK];
				end
				EIL_OFS_CONFIG_TWO: begin
					st_next.pud = reg_wdata[EIL_BIT_PUD];
				end
				EIL_OFS_BREAK_CTRL: begin
					st_next.break_clear_enable = reg_wdata[EIL_BIT_BREAK_CLEAR_ENABLE];
				end
				EIL_OFS_EVT_ENABLE: begin
					st_next.evt_en = reg_wdata[EIL_EVT_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// Sticky events; a fresh hit outranks a clear in the same cycle
		st_next.evt_sts = (st_reg.evt_sts & ~evt_clr) | evt_hit;
		// Read data valid in the cycle after the strobe only
		if (reg_rd) begin
			case (reg_addr)
				EIL_OFS_STATUS_CONTROL: begin
					// Ack bit always reads zero; pending ignores mask
					st_next.rdata[EIL_BIT_PENDING] = st_reg.latch;
					st_next.rdata[EIL_BIT_MASK]    = st_reg.mask;
					st_next.rdata[EIL_BIT_MODE]    = st_reg.mode;
				end
				EIL_OFS_CONFIG_TWO: begin
					st_next.rdata[EIL_BIT_PUD] = st_reg.pud;
				end
				EIL_OFS_BREAK_CTRL: begin
					st_next.rdata[EIL_BIT_BREAK_CLEAR_ENABLE] = st_reg.break_clear_enable;
				end
				EIL_OFS_EVT_STATUS: begin
					st_next.rdata[EIL_EVT_W-1:0] = st_reg.evt_sts;
				end
				EIL_OFS_EVT_ENABLE: begin
					st_next.rdata[EIL_EVT_W-1:0] = st_reg.evt_en;
				end
				default: begin
					st_next.rdata = 8'h00; // Unmapped reads return zero
				end
			endcase
		end
	end

	// Event hits and write-one-to-clear, one generate per event bit
	genvar gi;
	generate
		for (gi = 0; gi < EIL_EVT_W; gi++) begin : g_evt
			if (gi == EIL_EVT_SET) begin : g_set
				assign evt_hit[gi] = !st_reg.latch && st_next.latch;
			end else begin : g_clr
				assign evt_hit[gi] = st_reg.latch && !st_next.latch;
			end
			assign evt_clr[gi] = reg_wr && reg_addr == EIL_OFS_EVT_CLEAR && reg_wdata[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// State register; reset clears latch, mode and mask
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '{latch: 1'h0, ack_seen: 1'h0, mode: EIL_RST_MODE, mask: EIL_RST_MASK,
				pud: EIL_RST_PUD, break_clear_enable: EIL_RST_BREAK_CLEAR_ENABLE, evt_sts: '0, evt_en: '0, rdata: 8'h00};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs; the request is gated by both masks
	assign cpu_irq_req     = st_reg.latch && !st_reg.mask && !cpu_global_mask;
	assign cpu_vector_addr = EIL_VEC_HIGH; // Low byte follows at EIL_VEC_LOW
	assign pin_level_high  = sy.pin_level;
	assign pin_pullup_en   = !st_reg.pud;
	assign reg_rdata       = st_reg.rdata;
	assign evt_irq         = |(st_reg.evt_sts & st_reg.evt_en);

	////////////////////////////////////////////////////////////////////////
	// Checks on the latch, the register port and the request outputs

	// A settled falling edge always latches a request
	edge_sets_latch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		sy.fall_pulse |=> st_reg.latch)
		else $error("falling edge did not set the latch");

	// Low level keeps the request in level mode
	level_holds_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.mode && !sy.pin_level |=> st_reg.latch)
		else $error("low level in level mode lost the request");

	// Fetch in edge mode clears at once
	edge_ack_clears_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!st_reg.mode && vector_fetch && !sy.fall_pulse |=> !st_reg.latch)
		else $error("edge mode fetch did not clear the latch");

	// Level mode never drops the request with the pin low
	level_needs_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$fell(st_reg.latch) |-> $past(sy.pin_level) || !$past(st_reg.mode))
		else $error("level mode latch dropped while pin low");

	// Protected latch survives an acknowledge in break
	break_protect_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ack_wr && break_state && !st_reg.break_clear_enable && !vector_fetch && !st_reg.ack_seen && st_reg.latch
		|=> st_reg.latch)
		else $error("protected latch cleared in break");

	// Enabled break acknowledge clears
	break_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ack_wr && break_state && st_reg.break_clear_enable && !set_req |=> !st_reg.latch)
		else $error("enabled break acknowledge did not clear");

	// Pending flag follows the latch, ack bit reads zero
	pending_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == EIL_OFS_STATUS_CONTROL |=>
		reg_rdata[EIL_BIT_PENDING] == $past(st_reg.latch) && !reg_rdata[EIL_BIT_ACK])
		else $error("pending flag or ack bit read wrong");

	// No request while either mask is set
	mask_gates_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cpu_irq_req |-> st_reg.latch && !st_reg.mask && !cpu_global_mask)
		else $error("request reached processor while masked");

	// Pull-up control follows the configuration write
	pullup_ctl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_CONFIG_TWO |=> pin_pullup_en == !$past(reg_wdata[EIL_BIT_PUD]))
		else $error("pull-up control did not follow write");

	// Remembered ack with the pin high ends the request
	level_ack_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.mode && st_reg.ack_seen && sy.pin_level |=> !st_reg.latch)
		else $error("level mode ack and high pin did not clear");

	// An ack with the pin low is kept for later
	ack_remember_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.mode && st_reg.latch && ack_ok && !sy.pin_level && !sy.fall_pulse
		|=> st_reg.latch && st_reg.ack_seen)
		else $error("level mode ack not remembered");

	// Fetch with the pin low leaves the level request pending
	fetch_level_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.mode && vector_fetch && !sy.pin_level |=> st_reg.latch)
		else $error("level mode fetch cleared with pin low");

	// Low level alone does nothing in edge mode
	edge_low_ignored_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!st_reg.mode && !st_reg.latch && !sy.fall_pulse |=> !st_reg.latch)
		else $error("edge mode latched without an edge");

	// A remembered ack never outlives its request
	ack_seen_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!st_reg.latch |-> !st_reg.ack_seen)
		else $error("acknowledge held without a request");

	// Software acknowledge outside break clears an edge request
	ack_edge_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ack_wr && !break_state && !st_reg.mode && !sy.fall_pulse |=> !st_reg.latch)
		else $error("acknowledge write did not clear");

	// An edge right after an ack latches again
	new_edge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		ack_ok ##1 sy.fall_pulse |=> st_reg.latch)
		else $error("edge after acknowledge was lost");

	// Mode bit follows the status write
	mode_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_STATUS_CONTROL |=> st_reg.mode == $past(reg_wdata[EIL_BIT_MODE]))
		else $error("mode bit did not follow write");

	// Mask bit follows the status write
	mask_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_STATUS_CONTROL |=> st_reg.mask == $past(reg_wdata[EIL_BIT_MASK]))
		else $error("mask bit did not follow write");

	// Clear-enable follows the break control write
	break_clear_enable_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_BREAK_CTRL |=> st_reg.break_clear_enable == $past(reg_wdata[EIL_BIT_BREAK_CLEAR_ENABLE]))
		else $error("clear enable did not follow write");

	// Event enables follow their write
	evten_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_EVT_ENABLE |=> st_reg.evt_en == $past(reg_wdata[EIL_EVT_W-1:0]))
		else $error("event enable did not follow write");

	// Unmasked latch reaches the processor
	irq_unmasked_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.latch && !st_reg.mask && !cpu_global_mask |-> cpu_irq_req)
		else $error("unmasked request not presented");

	// Global mask blocks the request
	global_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cpu_global_mask |-> !cpu_irq_req)
		else $error("global mask did not block request");

	// Module mask blocks the request
	mask_blocks_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_reg.mask |-> !cpu_irq_req)
		else $error("module mask did not block request");

	// Read data is zero outside the cycle after a read
	rdata_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data present without a read");

	// Pull-up disable reads back as written
	config_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == EIL_OFS_CONFIG_TWO |=> reg_rdata[EIL_BIT_PUD] == !$past(pin_pullup_en))
		else $error("pull-up disable read wrong");

	// Mode and mask read back as held
	mode_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && reg_addr == EIL_OFS_STATUS_CONTROL |=>
		reg_rdata[EIL_BIT_MODE] == $past(st_reg.mode) && reg_rdata[EIL_BIT_MASK] == $past(st_reg.mask))
		else $error("mode or mask read wrong");

	// Addresses outside the map read zero
	unmapped_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_rd && (reg_addr < EIL_OFS_STATUS_CONTROL || reg_addr > EIL_OFS_EVT_ENABLE) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	// A fresh set-event hit is never lost to its clear
	evt_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		evt_hit[EIL_EVT_SET] |=> st_reg.evt_sts[EIL_EVT_SET])
		else $error("set event lost");

	// Clear write drops an idle event bit
	evt_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		reg_wr && reg_addr == EIL_OFS_EVT_CLEAR && reg_wdata[EIL_EVT_CLR] && !evt_hit[EIL_EVT_CLR]
		|=> !st_reg.evt_sts[EIL_EVT_CLR])
		else $error("event clear did not drop the bit");
endmodule

// File: tb/eil_pin_model.sv
`timescale 1ns/1ps
module eil_pin_model (
	input  wire logic sys_clk,
	input  wire logic drive_low,
	input  wire logic pullup_en,
	output logic      irq_pin_n
);
	logic float_reg = 1'h0;
	// A released pin with no pull-up wanders, so a stale high is never trusted
	always @(posedge sys_clk) begin
		float_reg <= ~float_reg;
	end
	// Pull-up holds the idle pin high only while it is connected
	assign irq_pin_n = drive_low ? 1'h0 : (pullup_en ? 1'h1 : float_reg);
endmodule

// File: tb/eil_ext_irq_tb.sv
`timescale 1ns/1ps
module eil_ext_irq_tb;
	import eil_pkg::*;
	logic        sys_clk, sys_rst, drive_low, irq_pin_n, reg_wr, reg_rd;
	logic        vector_fetch, break_state, cpu_global_mask;
	logic        cpu_irq_req, pin_level_high, pin_pullup_en, evt_irq;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [15:0] cpu_vector_addr;
	logic [31:0] seed;
	int          miscompares, compares;

	eil_ext_irq eil_ext_irq_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_pin_n(irq_pin_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .vector_fetch(vector_fetch), .break_state(break_state),
		.cpu_global_mask(cpu_global_mask), .cpu_irq_req(cpu_irq_req),
		.cpu_vector_addr(cpu_vector_addr), .pin_level_high(pin_level_high),
		.pin_pullup_en(pin_pullup_en), .evt_irq(evt_irq));
	eil_pin_model eil_pin_model_i (.sys_clk(sys_clk), .drive_low(drive_low),
		.pullup_en(pin_pullup_en), .irq_pin_n(irq_pin_n));

	////////////////////////////////////////////////////////////////////////////////
	// Expected status byte from pending, mask and mode
	function automatic logic [7:0] sc(input logic p, input logic k, input logic m);
		sc = 8'h00;
		sc[EIL_BIT_PENDING] = p;
		sc[EIL_BIT_MASK] = k;
		sc[EIL_BIT_MODE] = m;
	endfunction
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		xs = s ^ (s << 5);
	endfunction
	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Bus cycles: strobes last one cycle, read data land one cycle later
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Pin changes take three cycles to reach the latch; five leaves margin
	task automatic pin(input logic v);
		@(posedge sys_clk);
		drive_low <= v;
		cyc(5);
	endtask
	task automatic wait_req();
		int i;
		for (i = 0; i < 10 && cpu_irq_req !== 1'h1; i++) cyc(1);
		if (i == 10) begin
			miscompares++;
			results();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		{sys_rst, drive_low, reg_wr, reg_rd, vector_fetch} = 5'h10;
		{break_state, cpu_global_mask, reg_addr, reg_wdata} = 18'h0;
		seed = 32'h4205;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rd(EIL_OFS_STATUS_CONTROL, 8'h00);
		rd(EIL_OFS_CONFIG_TWO, 8'h00);
		rd(EIL_OFS_BREAK_CTRL, 8'h00);
		rd(8'h30, 8'h00);
		chk(pin_pullup_en, 16'h1);
		wr(EIL_OFS_EVT_ENABLE, 8'h03);
		$display("test reset done");
		// Edge mode: set, acknowledge with pin still low, fresh edge, fetch
		pin(1'h1);
		wait_req();
		chk(cpu_vector_addr, EIL_VEC_HIGH);
		chk({pin_level_high, evt_irq}, 16'h1);
		wr(EIL_OFS_STATUS_CONTROL, 8'h04);
		rd(EIL_OFS_STATUS_CONTROL, sc(0, 0, 0));
		pin(1'h0);
		pin(1'h1);
		rd(EIL_OFS_STATUS_CONTROL, sc(1, 0, 0));
		@(posedge sys_clk);
		vector_fetch <= 1'h1;
		@(posedge sys_clk);
		vector_fetch <= 1'h0;
		cyc(1);
		chk(cpu_irq_req, 16'h0);
		pin(1'h0);
		pin(1'h1);
		// Random module and global masks over a held request
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			cpu_global_mask <= seed[3];
			wr(EIL_OFS_STATUS_CONTROL, sc(0, seed[1], 0));
			cyc(1);
			chk(cpu_irq_req, {15'h0, !(seed[1] | seed[3])});
			rd(EIL_OFS_STATUS_CONTROL, sc(1, seed[1], 0));
		end
		cpu_global_mask <= 1'h0;
		seed = xs(seed);
		wr(EIL_OFS_CONFIG_TWO, seed[7:0]);
		cyc(1);
		chk(pin_pullup_en, {15'h0, !seed[EIL_BIT_PUD]});
		wr(EIL_OFS_CONFIG_TWO, 8'h00);
		$display("test edge done");
		// Break: acknowledge ignored, then honoured once clear-enable is set
		break_state <= 1'h1;
		wr(EIL_OFS_STATUS_CONTROL, 8'h04);
		rd(EIL_OFS_STATUS_CONTROL, sc(1, 0, 0));
		wr(EIL_OFS_BREAK_CTRL, 8'h01);
		wr(EIL_OFS_STATUS_CONTROL, 8'h04);
		break_state <= 1'h0;
		rd(EIL_OFS_STATUS_CONTROL, sc(0, 0, 0));
		wr(EIL_OFS_BREAK_CTRL, 8'h00);
		wr(EIL_OFS_EVT_CLEAR, 8'h03);
		rd(EIL_OFS_EVT_STATUS, 8'h00);
		chk(evt_irq, 16'h0);
		$display("test break done");
		// Level mode: acknowledge before and after the pin returns high
		wr(EIL_OFS_STATUS_CONTROL, sc(0, 0, 1));
		pin(1'h1);
		chk(evt_irq, 16'h1);
		// Handler masks and acknowledges while the pin is still low
		wr(EIL_OFS_STATUS_CONTROL, 8'h07);
		cyc(1);
		chk(cpu_irq_req, 16'h0);
		rd(EIL_OFS_STATUS_CONTROL, sc(1, 1, 1));
		pin(1'h0);
		rd(EIL_OFS_STATUS_CONTROL, sc(0, 1, 1));
		wr(EIL_OFS_STATUS_CONTROL, sc(0, 0, 1));
		pin(1'h1);
		pin(1'h0);
		rd(EIL_OFS_STATUS_CONTROL, sc(1, 0, 1));
		wr(EIL_OFS_STATUS_CONTROL, 8'h05);
		rd(EIL_OFS_STATUS_CONTROL, sc(0, 0, 1));
		wr(EIL_OFS_EVT_ENABLE, 8'h00);
		cyc(1);
		chk(evt_irq, 16'h0);
		// Reset in mid-run with the pin held low
		pin(1'h1);
		sys_rst <= 1'h1;
		cyc(2);
		chk(cpu_irq_req, 16'h0);
		sys_rst <= 1'h0;
		// Sampler restarts high, so the held-low pin shows as a new edge
		cyc(4);
		rd(EIL_OFS_STATUS_CONTROL, sc(1, 0, 0));
		$display("test level done");
		results();
	end
endmodule
